// *** logic/hps_pkg.sv ***
// Package for the hot-plug slot control and status register bank
package hps_pkg;
    localparam logic [7:0] hps_slot_addr = 8'hf8;
    localparam logic [7:0] hps_dll_addr = 8'hfc;
    localparam int hps_cmd_done_cycles = 4;
    // Control field positions
    localparam int hps_ab_en_bit = 0;
    localparam int hps_pf_en_bit = 1;
    localparam int hps_pd_en_bit = 3;
    localparam int hps_cc_en_bit = 4;
    localparam int hps_hp_en_bit = 5;
    localparam int hps_attn_lo = 6;
    localparam int hps_pwr_ind_lo = 8;
    localparam int hps_pwr_ctl_bit = 10;
    localparam int hps_dll_en_bit = 12;
    // Status field positions
    localparam int hps_ab_st_bit = 16;
    localparam int hps_pf_st_bit = 17;
    localparam int hps_ls_chg_bit = 18;
    localparam int hps_pd_chg_bit = 19;
    localparam int hps_cc_st_bit = 20;
    localparam int hps_ls_state_bit = 21;
    localparam int hps_pd_state_bit = 22;
    localparam int hps_dll_chg_bit = 24;
    // Indicator reset and reserved codes
    localparam logic [1:0] hps_ind_reset = 2'h3;
    localparam logic [1:0] hps_ind_rsvd = 2'h0;

    typedef struct packed {
        logic ab_en;
        logic pf_en;
        logic pd_en;
        logic cc_en;
        logic hp_en;
        logic [1:0] attn;
        logic [1:0] pwr_ind;
        logic pwr_off;
        logic dll_en;
    } hps_ctrl_type;

    typedef struct packed {
        logic ab;
        logic pf;
        logic pd;
        logic cc;
        logic dll;
    } hps_evt_type;

    // Indicator message request toward the link
    typedef struct packed {
        logic attn_send;
        logic [1:0] attn_code;
        logic pwr_send;
        logic [1:0] pwr_code;
    } hps_msg_type;

    typedef enum logic [1:0] {
        hps_cmd_idle = 2'b01,
        hps_cmd_busy = 2'b10
    } hps_cmd_type;

    typedef struct packed {
        hps_ctrl_type ctrl;
        hps_evt_type evt;
        logic pd_prev;
        logic ls_prev;
        logic dll_prev;
        hps_cmd_type cmd;
        logic [7:0] cmd_cnt;
        hps_msg_type msg;
        logic [31:0] rdata;
        logic irq;
    } hps_state_type;
endpackage

// *** logic/hps_slot_regs.sv ***
// Slot control and slot status registers with APB slave
`timescale 1ns/10ps
module hps_slot_regs
    import hps_pkg::*;
#(
    parameter bit slot_implemented = 1'b1,
    parameter int cmd_done_cycles = hps_cmd_done_cycles
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic button_press,
    input wire logic power_fault,
    input wire logic retention_latch_sensor,
    input wire logic card_present,
    input wire logic link_active,
    output logic attn_msg_send,
    output logic [1:0] attn_msg_code,
    output logic pwr_msg_send,
    output logic [1:0] pwr_msg_code,
    output logic [1:0] attn_indicator,
    output logic [1:0] pwr_indicator,
    output logic slot_power_off,
    output logic cmd_busy,
    output logic hp_irq
);
    hps_state_type s_reg, s_next;

    // Word decode, used for both read and write paths
    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[31:2] == {24'h000000, off[7:2]});
    endfunction

    function automatic logic [31:0] read_word(input hps_state_type s, input logic [31:0] a,
                                              input logic pres);
        logic [31:0] w;
        w = 32'h00000000;
        if (hit(a, hps_slot_addr)) begin
            w[hps_ab_en_bit] = s.ctrl.ab_en;
            w[hps_pf_en_bit] = s.ctrl.pf_en;
            w[hps_pd_en_bit] = s.ctrl.pd_en;
            w[hps_cc_en_bit] = s.ctrl.cc_en;
            w[hps_hp_en_bit] = s.ctrl.hp_en;
            w[hps_attn_lo +: 2] = s.ctrl.attn;
            w[hps_pwr_ind_lo +: 2] = s.ctrl.pwr_ind;
            w[hps_pwr_ctl_bit] = s.ctrl.pwr_off;
            w[hps_dll_en_bit] = s.ctrl.dll_en;
            w[hps_ab_st_bit] = s.evt.ab;
            w[hps_pf_st_bit] = s.evt.pf;
            w[hps_ls_chg_bit] = 1'b0;
            w[hps_pd_chg_bit] = s.evt.pd;
            w[hps_cc_st_bit] = s.evt.cc;
            w[hps_ls_state_bit] = s.ls_prev;
            w[hps_pd_state_bit] = pres;
            w[hps_dll_chg_bit] = s.evt.dll;
        end
        read_word = w;
    endfunction

    logic wr_acc;
    logic slot_hit;
    logic pres_now;
    logic [31:0] wmask;

    // Access phase completes in one cycle; unmapped words read zero
    assign wr_acc = psel && penable && pwrite;
    assign slot_hit = hit(paddr, hps_slot_addr);
    assign pres_now = slot_implemented ? card_present : 1'b1;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        logic [31:0] wd;
        logic ctl_lo_wr;
        logic ctl_hi_wr;
        logic w1c_lo;
        logic w1c_hi;
        wd = pwdata & wmask;
        ctl_lo_wr = wr_acc && slot_hit && pstrb[0];
        ctl_hi_wr = wr_acc && slot_hit && pstrb[1];
        w1c_lo = wr_acc && slot_hit && pstrb[2];
        w1c_hi = wr_acc && slot_hit && pstrb[3];
        s_next = s_reg;
        s_next.msg.attn_send = 1'b0;
        s_next.msg.pwr_send = 1'b0;
        // Control writes, byte lane 0 and 1
        if (ctl_lo_wr) begin
            s_next.ctrl.ab_en = wd[hps_ab_en_bit];
            s_next.ctrl.pf_en = wd[hps_pf_en_bit];
            s_next.ctrl.pd_en = wd[hps_pd_en_bit];
            s_next.ctrl.cc_en = wd[hps_cc_en_bit];
            s_next.ctrl.hp_en = wd[hps_hp_en_bit];
            // Reserved code is kept as written and driven unchanged on attn_indicator
            s_next.ctrl.attn = wd[hps_attn_lo +: 2];
            s_next.msg.attn_send = 1'b1;
            s_next.msg.attn_code = wd[hps_attn_lo +: 2];
        end
        if (ctl_hi_wr) begin
            s_next.ctrl.pwr_ind = wd[hps_pwr_ind_lo +: 2];
            s_next.msg.pwr_send = 1'b1;
            s_next.msg.pwr_code = wd[hps_pwr_ind_lo +: 2];
            s_next.ctrl.pwr_off = wd[hps_pwr_ctl_bit];
            s_next.ctrl.dll_en = wd[hps_dll_en_bit];
        end
        // Write-one-to-clear first, so a same-cycle event overrides it
        if (w1c_lo) begin
            if (wd[hps_ab_st_bit]) s_next.evt.ab = 1'b0;
            if (wd[hps_pf_st_bit]) s_next.evt.pf = 1'b0;
            if (wd[hps_pd_chg_bit]) s_next.evt.pd = 1'b0;
            if (wd[hps_cc_st_bit]) s_next.evt.cc = 1'b0;
        end
        if (w1c_hi && wd[hps_dll_chg_bit]) begin
            s_next.evt.dll = 1'b0;
        end
        // Slot commands: a control write while idle starts a short command timer
        unique case (s_reg.cmd)
            hps_cmd_idle: begin
                if (ctl_lo_wr || ctl_hi_wr) begin
                    s_next.cmd = hps_cmd_busy;
                    s_next.cmd_cnt = 8'(cmd_done_cycles - 1);
                end
            end
            hps_cmd_busy: begin
                if (s_reg.cmd_cnt == 8'h00) begin
                    s_next.cmd = hps_cmd_idle;
                    s_next.evt.cc = 1'b1;
                end else begin
                    s_next.cmd_cnt = s_reg.cmd_cnt - 8'h01;
                end
            end
        endcase
        // Hardware events win over a clear in the same cycle
        if (button_press) s_next.evt.ab = 1'b1;
        if (power_fault) s_next.evt.pf = 1'b1;
        if (pres_now != s_reg.pd_prev) s_next.evt.pd = 1'b1;
        if (link_active != s_reg.dll_prev) s_next.evt.dll = 1'b1;
        s_next.pd_prev = pres_now;
        s_next.ls_prev = retention_latch_sensor;
        s_next.dll_prev = link_active;
        // Read data registered at setup, steady through access
        if (psel && !penable && !pwrite) begin
            s_next.rdata = read_word(s_reg, paddr, s_reg.pd_prev);
        end
        // Interrupt from registered state only, glitch free
        s_next.irq = s_reg.ctrl.hp_en && (
            (s_reg.evt.ab && s_reg.ctrl.ab_en) ||
            (s_reg.evt.pf && s_reg.ctrl.pf_en) ||
            (s_reg.evt.pd && s_reg.ctrl.pd_en) ||
            (s_reg.evt.cc && s_reg.ctrl.cc_en) ||
            (s_reg.evt.dll && s_reg.ctrl.dll_en));
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.ctrl.attn <= hps_ind_reset;
            s_reg.ctrl.pwr_ind <= hps_ind_reset;
            s_reg.msg.attn_code <= hps_ind_reset;
            s_reg.msg.pwr_code <= hps_ind_reset;
            s_reg.pd_prev <= 1'b1;
            s_reg.cmd <= hps_cmd_idle;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.rdata;
    assign attn_msg_send = s_reg.msg.attn_send;
    assign attn_msg_code = s_reg.msg.attn_code;
    assign pwr_msg_send = s_reg.msg.pwr_send;
    assign pwr_msg_code = s_reg.msg.pwr_code;
    assign attn_indicator = s_reg.ctrl.attn;
    assign pwr_indicator = s_reg.ctrl.pwr_ind;
    assign slot_power_off = s_reg.ctrl.pwr_off;
    assign cmd_busy = (s_reg.cmd == hps_cmd_busy);
    assign hp_irq = s_reg.irq;
endmodule

// *** tb/hps_slot_checker.sv ***
// Concurrent checks on the slot register bank ports
`timescale 1ns/10ps
module hps_slot_checker
    import hps_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic attn_msg_send,
    input wire logic [1:0] attn_msg_code,
    input wire logic pwr_msg_send,
    input wire logic [1:0] pwr_msg_code,
    input wire logic [1:0] attn_indicator,
    input wire logic [1:0] pwr_indicator,
    input wire logic slot_power_off,
    input wire logic cmd_busy
);
    logic wr;
    logic w0;
    logic w1;
    // Accepted writes to the control byte lanes
    assign wr = psel && penable && pwrite && paddr == {24'h0, hps_slot_addr};
    assign w0 = wr && pstrb[0];
    assign w1 = wr && pstrb[1];
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Command runs for a fixed count, then finishes
    sequence s_busy4;
        cmd_busy [*4] ##1 !cmd_busy;
    endsequence
    property p_am; w0 |=> attn_msg_send && attn_msg_code == $past(pwdata[7:6]); endproperty
    a_am: assert property (p_am) else $error("attention message wrong");
    property p_pm; w1 |=> pwr_msg_send && pwr_msg_code == $past(pwdata[9:8]); endproperty
    a_pm: assert property (p_pm) else $error("power message wrong");
    property p_ms; attn_msg_send |-> attn_indicator == attn_msg_code; endproperty
    a_ms: assert property (p_ms) else $error("message not matching field");
    property p_ai; $changed(attn_indicator) |-> $past(w0); endproperty
    a_ai: assert property (p_ai) else $error("attention field moved alone");
    property p_pi; $changed(pwr_indicator) |-> $past(w1); endproperty
    a_pi: assert property (p_pi) else $error("power field moved alone");
    property p_po; w1 |=> slot_power_off == $past(pwdata[10]); endproperty
    a_po: assert property (p_po) else $error("power control wrong");
    property p_pc; $changed(slot_power_off) |-> $past(w1); endproperty
    a_pc: assert property (p_pc) else $error("power control moved alone");
    property p_cb; (w0 || w1) && !cmd_busy |=> s_busy4; endproperty
    a_cb: assert property (p_cb) else $error("command timing wrong");
endmodule
bind hps_slot_regs hps_slot_checker i_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .attn_msg_send, .attn_msg_code, .pwr_msg_send, .pwr_msg_code,
    .attn_indicator, .pwr_indicator, .slot_power_off, .cmd_busy);

// *** tb/hps_slot_hw.sv ***
// Behavioural model of the slot sensors and button
`timescale 1ns/10ps
module hps_slot_hw (
    input wire logic clk,
    output logic button_press,
    output logic power_fault,
    output logic retention_latch_sensor,
    output logic card_present,
    output logic link_active
);
    logic [4:0] s = 5'h08;
    // Slot starts closed, populated, link down
    assign {link_active, card_present, retention_latch_sensor, power_fault, button_press} = s;
    // Toggle chosen lines just after an edge
    task automatic kick(input logic [4:0] m);
        @(posedge clk);
        s <= s ^ m;
    endtask
endmodule

// *** tb/test_hps_slot_regs.sv ***
// Self-checking bench for the slot register bank
`timescale 1ns/10ps
module test_hps_slot_regs import hps_pkg::*;;
    localparam logic [31:0] sa = {24'h0, hps_slot_addr};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, attn_msg_send, pwr_msg_send, slot_power_off, cmd_busy, hp_irq;
    logic [1:0] attn_msg_code, pwr_msg_code, attn_indicator, pwr_indicator;
    logic button_press, power_fault, retention_latch_sensor, card_present, link_active;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    hps_slot_regs i_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .button_press, .power_fault, .retention_latch_sensor,
        .card_present, .link_active, .attn_msg_send, .attn_msg_code, .pwr_msg_send,
        .pwr_msg_code, .attn_indicator, .pwr_indicator, .slot_power_off, .cmd_busy, .hp_irq);
    hps_slot_hw i_hw (.clk, .button_press, .power_fault, .retention_latch_sensor,
        .card_present, .link_active);
    always #2.5 clk = ~clk;
    // Hang guard, far above the roughly 80 cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [31:0] a, e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(n, e, rd);
        // Slave never refuses and never stalls
        chk("slverr", 32'h0, {31'h0, pslverr});
        chk("ready", 32'h1, {31'h0, pready});
    endtask
    task automatic t_ctrl();
        apb(1'b1, sa, 32'h0000167b, 4'h3);
        repeat (8) @(posedge clk);
        rdc("ctrl", sa, 32'h0050167b);
        chk("pins", 32'h16, {27'h0, slot_power_off, attn_indicator, pwr_indicator});
        chk("irq on", 32'h1, {31'h0, hp_irq});
        apb(1'b1, sa, 32'h00100000, 4'h4);
        rdc("done clear", sa, 32'h0040167b);
        chk("irq off", 32'h0, {31'h0, hp_irq});
    endtask
    task automatic t_events();
        i_hw.kick(5'h1f);
        i_hw.kick(5'h0b);
        repeat (3) @(posedge clk);
        rdc("events", sa, 32'h016b167b);
        chk("irq ev", 32'h1, {31'h0, hp_irq});
        apb(1'b1, sa, 32'h017f0000, 4'hc);
        rdc("cleared", sa, 32'h0060167b);
    endtask
    task automatic t_mask();
        apb(1'b1, sa, 32'h0000005b, 4'h1);
        i_hw.kick(5'h01);
        i_hw.kick(5'h01);
        repeat (8) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, hp_irq});
        rdc("masked", sa, 32'h0071165b);
        apb(1'b1, sa, 32'h0000007b, 4'h1);
        repeat (2) @(posedge clk);
        chk("irq unmask", 32'h1, {31'h0, hp_irq});
        rdc("unmapped", 32'hfc, 32'h0);
        apb(1'b1, 32'hfc, 32'hffffffff, 4'hf);
        repeat (8) @(posedge clk);
        rdc("kept", sa, 32'h0071167b);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rdc("reset", sa, 32'h004003c0);
        t_ctrl();
        t_events();
        t_mask();
        stop_test();
    end
endmodule
